// ===== rtl/sram_host.sv
// Host controller driving a 256x4 asynchronous static RAM
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_host #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  // Standby control
  input wire logic standby_req,
  output logic standby_active,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_din,
  input wire logic [DATA_W-1:0] mem_dout,
  output logic chip_enable_active_low,
  output logic chip_enable_active_high,
  output logic write_strobe_n,
  output logic output_float_control
);
  localparam logic [7:0] READ_CYC = 8'(`READ_CYCLES);
  localparam logic [7:0] WRITE_CYC = 8'(`WRITE_CYCLES);
  localparam logic [7:0] WP_CYC = 8'(`WRITE_PULSE_CYCLES);
  localparam logic [7:0] ACC_CYC = 8'(`ACCESS_CYCLES);
  localparam logic [7:0] REC_CYC = 8'(`RECOVERY_CYCLES);
  localparam logic [7:0] DS_CYC = 8'(`DATA_SETUP_CYCLES);

  sram_host_pkg::state_e state_reg;
  logic [7:0] cnt_reg;
  logic last;
  logic [7:0] read_age_reg;
  logic [7:0] din_age_reg;

  // One step down a cycle count; shared by every timed state
  function automatic logic [7:0] count_down(input logic [7:0] value);
    return value - 8'h01;
  endfunction : count_down

  // Ages stop at the top rather than wrap back to a short age
  function automatic logic [7:0] age_up(input logic [7:0] value);
    if (value == 8'hff) begin
      return value;
    end
    return value + 8'h01;
  endfunction : age_up

  assign last = (cnt_reg == 8'h01);
  assign req_ready = (state_reg == sram_host_pkg::ST_IDLE) && !standby_req;
  assign standby_active = (state_reg == sram_host_pkg::ST_STANDBY);

  // Sequencer; every access spans a full cycle time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= sram_host_pkg::ST_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        sram_host_pkg::ST_IDLE: begin
          if (standby_req) begin
            state_reg <= sram_host_pkg::ST_STANDBY;
          end else if (req_valid && req_write) begin
            state_reg <= sram_host_pkg::ST_WRITE;
            cnt_reg <= WP_CYC;
          end else if (req_valid) begin
            state_reg <= sram_host_pkg::ST_READ;
            cnt_reg <= READ_CYC;
          end
        end
        sram_host_pkg::ST_READ: begin
          cnt_reg <= count_down(cnt_reg);
          if (last) begin
            state_reg <= sram_host_pkg::ST_IDLE;
          end
        end
        sram_host_pkg::ST_WRITE: begin
          cnt_reg <= count_down(cnt_reg);
          if (last) begin
            state_reg <= sram_host_pkg::ST_WREC;
            cnt_reg <= WRITE_CYC - WP_CYC;
          end
        end
        sram_host_pkg::ST_WREC: begin
          cnt_reg <= count_down(cnt_reg);
          if (last) begin
            state_reg <= sram_host_pkg::ST_IDLE;
          end
        end
        sram_host_pkg::ST_STANDBY: begin
          if (!standby_req) begin
            state_reg <= sram_host_pkg::ST_RECOVER;
            cnt_reg <= REC_CYC;
          end
        end
        sram_host_pkg::ST_RECOVER: begin
          cnt_reg <= count_down(cnt_reg);
          if (last) begin
            state_reg <= sram_host_pkg::ST_IDLE;
          end
        end
        default: state_reg <= sram_host_pkg::ST_IDLE;
      endcase
    end
  end

  // Address and data held for the whole access, past the strobe rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr <= '0;
      mem_din <= '0;
    end else if (req_ready && req_valid) begin
      mem_addr <= req_addr;
      mem_din <= req_wdata;
    end
  end

  // Pin levels: selected only during accesses, deselected in standby
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chip_enable_active_low <= 1'b1;
      chip_enable_active_high <= 1'b0;
      write_strobe_n <= 1'b1;
      output_float_control <= 1'b1;
    end else begin
      chip_enable_active_low <= 1'b1;
      chip_enable_active_high <= 1'b0;
      write_strobe_n <= 1'b1;
      output_float_control <= 1'b1;
      if (req_ready && req_valid) begin
        chip_enable_active_low <= 1'b0;
        chip_enable_active_high <= 1'b1;
        write_strobe_n <= !req_write;
        output_float_control <= req_write;
      end else if (state_reg == sram_host_pkg::ST_READ && !last) begin
        chip_enable_active_low <= 1'b0;
        chip_enable_active_high <= 1'b1;
        output_float_control <= 1'b0;
      end else if (state_reg == sram_host_pkg::ST_WRITE && !last) begin
        chip_enable_active_low <= 1'b0;
        chip_enable_active_high <= 1'b1;
        write_strobe_n <= 1'b0;
      end
    end
  end

  // Sample read data at the end of the cycle, exactly one access time after the select
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsp_rdata <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == sram_host_pkg::ST_READ && last) begin
        rsp_rdata <= mem_dout;
        rsp_valid <= 1'b1;
      end
    end
  end

  // Cycles the pins have stood in the read setting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_age_reg <= 8'h00;
    end else if (!chip_enable_active_low && chip_enable_active_high &&
                 !output_float_control) begin
      read_age_reg <= age_up(read_age_reg);
    end else begin
      read_age_reg <= 8'h00;
    end
  end

  // Cycles since address and write data were last loaded
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      din_age_reg <= 8'h00;
    end else if (req_ready && req_valid) begin
      din_age_reg <= 8'h00;
    end else begin
      din_age_reg <= age_up(din_age_reg);
    end
  end

  a_standby_desel: assert property (
    @(posedge clock) disable iff (!reset_n)
    standby_active |-> chip_enable_active_low && !chip_enable_active_high)
    else $error("chip selected in standby");
  a_write_float: assert property (
    @(posedge clock) disable iff (!reset_n)
    !write_strobe_n |-> output_float_control && !chip_enable_active_low &&
      chip_enable_active_high)
    else $error("bad pins during write");
  a_write_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    !write_strobe_n ##1 write_strobe_n |-> $stable(mem_din) && $stable(mem_addr))
    else $error("write data moved at strobe rise");
  a_read_space: assert property (
    @(posedge clock) disable iff (!reset_n)
    rsp_valid |-> $past(state_reg, 21) == sram_host_pkg::ST_IDLE &&
      $past(state_reg) == sram_host_pkg::ST_READ)
    else $error("read cycle too short");
  a_write_space: assert property (
    @(posedge clock) disable iff (!reset_n)
    $fell(write_strobe_n) |-> !req_ready [*8] ##1 !req_ready [*8] ##1
      !req_ready [*4])
    else $error("write cycle too short");
  a_recover_wait: assert property (
    @(posedge clock) disable iff (!reset_n)
    $fell(standby_active) |-> !req_ready [*8] ##1 !req_ready [*8] ##1
      !req_ready [*4])
    else $error("access before recovery");
  a_read_strobe: assert property (
    @(posedge clock) disable iff (!reset_n)
    !output_float_control |-> write_strobe_n && !chip_enable_active_low)
    else $error("outputs on outside a read");
  a_rsp_pulse: assert property (
    @(posedge clock) disable iff (!reset_n)
    rsp_valid |=> !rsp_valid)
    else $error("response not a pulse");
  a_access_time: assert property (
    @(posedge clock) disable iff (!reset_n)
    rsp_valid |-> read_age_reg >= ACC_CYC)
    else $error("read data taken before access time");
  a_data_setup: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(write_strobe_n) |-> din_age_reg >= DS_CYC)
    else $error("write data set up too late");
  a_addr_steady: assert property (
    @(posedge clock) disable iff (!reset_n)
    !write_strobe_n |=> $stable(mem_addr) && $stable(mem_din))
    else $error("address moved during write pulse");
endmodule : sram_host

// ===== common/sram_host_consts.svh
// Timing constants for the static RAM host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define READ_CYCLE_NS 200
`define WRITE_CYCLE_NS 200
`define WRITE_PULSE_NS 85
`define DATA_SETUP_NS 65
`define ACCESS_NS 200
`define RECOVERY_NS 200
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES `CYC_UP(`READ_CYCLE_NS)
`define WRITE_CYCLES `CYC_UP(`WRITE_CYCLE_NS)
`define WRITE_PULSE_CYCLES `CYC_UP(`WRITE_PULSE_NS)
`define DATA_SETUP_CYCLES `CYC_UP(`DATA_SETUP_NS)
`define ACCESS_CYCLES `CYC_UP(`ACCESS_NS)
`define RECOVERY_CYCLES `CYC_UP(`RECOVERY_NS)
`endif

// ===== common/sram_host_pkg.sv
// Types for the static RAM host controller
package sram_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_WREC = 3'b011,
    ST_STANDBY = 3'b100,
    ST_RECOVER = 3'b101
  } state_e;
endpackage : sram_host_pkg

// ===== bench/sram_model.sv
// Behavioural 256x4 static RAM on the far side of the host
`timescale 1ns/1ps
module sram_model #(
  parameter int DELAY_NS = 0
) (
  // Host pins
  input wire logic [7:0] mem_addr,
  input wire logic [3:0] mem_din,
  input wire logic chip_enable_active_low,
  input wire logic chip_enable_active_high,
  input wire logic write_strobe_n,
  input wire logic output_float_control,
  // Read data
  output logic [3:0] mem_dout
);
  logic [3:0] cells [256];
  logic [3:0] held;
  logic sel;
  logic drive;
  logic settled = 1'b0;
  assign sel = !chip_enable_active_low &&
    chip_enable_active_high;
  assign drive = sel && write_strobe_n &&
    !output_float_control;
  // Writes land only while selected with the strobe low
  always @* begin
    if (sel && !write_strobe_n) begin
      cells[mem_addr] = mem_din;
    end
  end
  always @* begin
    if (drive) begin
      held = cells[mem_addr];
    end
  end
  // Data settles a full delay after each select; a deselect floats at once
  always @(drive or mem_addr) begin
    settled = 1'b0;
    if (drive) begin
      #(DELAY_NS);
      settled = 1'b1;
    end
  end
  // Unsettled or floating bus shows the inverse, so a mistimed sample fails
  assign mem_dout = (drive && settled) ?
    cells[mem_addr] : ~held;
endmodule : sram_model

// ===== bench/sram_host_bench.sv
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_host_bench;
  logic clock = 0, reset_n = 0, req_valid = 0, req_write = 0;
  logic standby_req = 0, req_ready, rsp_valid, standby_active;
  logic [7:0] req_addr = 8'h00, mem_addr;
  logic [3:0] req_wdata = 4'h0, rsp_rdata, mem_din, mem_dout;
  logic ce_n, ce, write_strobe_n, output_float_control;
  int err_count = 0, checks = 0, n, busy;
  always #5 clock = ~clock;
  sram_host i_sram_host (.clock(clock), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid), .standby_req(standby_req),
    .standby_active(standby_active), .mem_addr(mem_addr),
    .mem_din(mem_din), .mem_dout(mem_dout), .chip_enable_active_low(ce_n),
    .chip_enable_active_high(ce), .write_strobe_n(write_strobe_n),
    .output_float_control(output_float_control));
  // Slow answer: data settles well after the enables
  sram_model #(.DELAY_NS(150)) i_sram_model (.mem_addr(mem_addr),
    .mem_din(mem_din), .chip_enable_active_low(ce_n),
    .chip_enable_active_high(ce), .write_strobe_n(write_strobe_n),
    .output_float_control(output_float_control), .mem_dout(mem_dout));
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic issue(input logic wr, input logic [7:0] a,
                       input logic [3:0] d);
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, wr, a, d};
    @(negedge clock);
    req_valid = 0;
    check("busy", 8'(req_ready), 8'h00);
  endtask : issue
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    issue(1'b1, a, d);
    n = 0;
    busy = 0;
    repeat (25) begin
      if (!req_ready) busy++;
      if (!write_strobe_n) begin
        n++;
        check("sel", 8'({ce_n, ce}), 8'h01);
        check("waddr", mem_addr, a);
        check("wdata", 8'(mem_din), 8'(d));
      end
      @(negedge clock);
    end
    check("pulse", 8'(n), 8'(`WRITE_PULSE_CYCLES));
    check("wcycle", 8'(busy), 8'(`WRITE_CYCLES));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    issue(1'b0, a, 4'h0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check("lat", 8'(n), 8'(`READ_CYCLES));
    check("rdata", 8'(rsp_rdata), 8'(exp));
    check("idle", 8'({ce_n, ce}), 8'h02);
    check("float", 8'(output_float_control), 8'h01);
  endtask : rd
  task automatic t_corners;
    wr(8'h00, 4'ha);
    wr(8'hff, 4'h5);
    rd(8'h00, 4'ha);
    rd(8'hff, 4'h5);
    wr(8'h80, 4'hf);
    rd(8'h80, 4'hf);
    $display("test corners done");
  endtask : t_corners
  task automatic t_standby;
    standby_req = 1'b1;
    repeat (3) @(negedge clock);
    check("stby", 8'({standby_active, req_ready}), 8'h02);
    check("desel", 8'({ce_n, ce}), 8'h02);
    standby_req = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    // One edge leaves standby, then the full recovery count runs
    check("recov", 8'(n), 8'(`RECOVERY_CYCLES + 1));
    rd(8'hff, 4'h5);
    $display("test standby done");
  endtask : t_standby
  task automatic test_done;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1;
    t_corners;
    t_standby;
    test_done;
  end
  initial begin
    #50000;
    err_count++;
    test_done;
  end
endmodule : sram_host_bench
